// ### smp_poll_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "smp_regs_map.vh"
module smp_poll_regs #(
    parameter LOOP_BASE_CYCLES = (`SMP_CLK_HZ / 1000) * `SMP_LOOP_BASE_MS
) (
    input  wire        mclk,
    input  wire        srst,
    // Register port behind the device's serial slave
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // Poll engine request, one pulse per slot visit
    output reg         poll_start,
    output reg  [2:0]  poll_slot,
    output reg         poll_restart,
    output reg         poll_check,
    output reg  [1:0]  poll_format,
    output reg         poll_block,
    output reg         poll_literal,
    output reg  [7:0]  poll_block_cmd,
    // Result of one slot transfer, same clock
    input  wire        result_valid,
    input  wire [2:0]  result_slot,
    input  wire        result_noack,
    input  wire        result_check_err,
    input  wire        result_timeout,
    input  wire        result_out_of_limit,
    input  wire        result_invalid_code,
    input  wire        result_overtemp,
    // Steering of module temperature sources
    output reg         remote_a_to_modules_01,
    output reg         remote_b_to_modules_23,
    output reg         modules_from_hub,
    output reg  [3:0]  poll_temp_hysteresis,
    output reg         poll_master_enable,
    output wire        error_alert
);
    // ========================================================
    // Register storage
    reg [7:0]  repeated_start_enable;
    reg [7:0]  error_check_enable;
    reg [7:0]  format_select_low;
    reg [7:0]  format_select_high;
    reg [7:0]  master_control;
    reg [7:0]  block_cmd;
    reg [7:0]  loop_cfg;
    reg [7:0]  noack_status;
    reg [7:0]  check_error_status;
    reg [7:0]  timeout_status;
    reg [7:0]  limit_status;
    reg [7:0]  invalid_code_status;
    reg [7:0]  overtemp_status;
    reg [7:0]  noack_mask;
    reg [7:0]  check_error_mask;
    reg [7:0]  timeout_mask;

    // One-hot bit for a slot number
    function [7:0] slot_bit;
        input [2:0] s;
        begin
            slot_bit = 8'h01 << s;
        end
    endfunction

    // Two-bit format field of a slot
    function [1:0] slot_fmt;
        input [2:0]  s;
        input [15:0] f;
        begin
            slot_fmt = f[{s, 1'b0} +: 2];
        end
    endfunction

    // Next value of a status byte: the slot's bit follows its latest
    // result, so a condition that went away clears on the next visit
    function [7:0] track;
        input [7:0] old;
        input [7:0] one_hot;
        input       flag;
        begin
            if (flag)
                track = old | one_hot;
            else
                track = old & ~one_hot;
        end
    endfunction

    // ========================================================
    // Host writes to configuration and masks
    always @(posedge mclk)
    begin
        if (srst)
        begin
            repeated_start_enable <= `SMP_R_RESTART;
            error_check_enable    <= `SMP_R_CHECK_EN;
            format_select_low     <= `SMP_R_FMT_LOW;
            format_select_high    <= `SMP_R_FMT_HIGH;
            master_control        <= `SMP_R_CONTROL;
            block_cmd             <= `SMP_R_BLOCK_CMD;
            loop_cfg              <= `SMP_R_LOOP_CFG;
            noack_mask            <= `SMP_R_ZERO;
            check_error_mask      <= `SMP_R_ZERO;
            timeout_mask          <= `SMP_R_ZERO;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `SMP_A_RESTART:      repeated_start_enable <= reg_wdata;
                `SMP_A_CHECK_EN:     error_check_enable <= reg_wdata;
                `SMP_A_FMT_LOW:      format_select_low <= reg_wdata;
                `SMP_A_FMT_HIGH:     format_select_high <= reg_wdata;
                `SMP_A_CONTROL:      master_control <= reg_wdata;
                `SMP_A_BLOCK_CMD:    block_cmd <= reg_wdata;
                `SMP_A_LOOP_CFG:     loop_cfg <= reg_wdata;
                `SMP_A_NOACK_MASK:   noack_mask <= reg_wdata;
                `SMP_A_CHECK_MASK:   check_error_mask <= reg_wdata;
                `SMP_A_TIMEOUT_MASK: timeout_mask <= reg_wdata;
                default:             ;
            endcase
        end
    end

    // ========================================================
    // Status capture; status bits follow the latest result of a slot
    // so a limit flag clears once the reading is back in range.
    // Nothing clears status on a read, so a host read never races a
    // hardware set; the price is that a fault which came and went
    // between two host reads leaves no trace.
    wire [7:0] rbit = slot_bit(result_slot);
    wire [7:0] next_noack_status =
        track(noack_status, rbit, result_noack);
    wire [7:0] next_check_error_status =
        track(check_error_status, rbit, result_check_err);
    wire [7:0] next_timeout_status =
        track(timeout_status, rbit, result_timeout);
    wire [7:0] next_limit_status =
        track(limit_status, rbit, result_out_of_limit);
    // Only slots 0-4 can report a reserved code; spare bits stay zero
    wire [7:0] next_invalid_code_status =
        track(invalid_code_status, rbit, result_invalid_code)
        & `SMP_INVALID_MASK;
    wire [7:0] next_overtemp_status =
        track(overtemp_status, rbit, result_overtemp);

    // Register the status bytes on each result
    always @(posedge mclk)
    begin
        if (srst)
        begin
            noack_status        <= `SMP_R_ZERO;
            check_error_status  <= `SMP_R_ZERO;
            timeout_status      <= `SMP_R_ZERO;
            limit_status        <= `SMP_R_ZERO;
            invalid_code_status <= `SMP_R_ZERO;
            overtemp_status     <= `SMP_R_ZERO;
        end
        else if (result_valid)
        begin
            noack_status        <= next_noack_status;
            check_error_status  <= next_check_error_status;
            timeout_status      <= next_timeout_status;
            limit_status        <= next_limit_status;
            invalid_code_status <= next_invalid_code_status;
            overtemp_status     <= next_overtemp_status;
        end
    end

    // Per-class alert requests; masks gate only the alert, status keeps
    // the record so software still sees a masked fault
    wire noack_req = |(noack_status & ~noack_mask);
    wire check_req = |(check_error_status & ~check_error_mask);
    wire tmout_req = |(timeout_status & ~timeout_mask);
    assign error_alert = noack_req | check_req | tmout_req;

    // ========================================================
    // Registered read data; unmapped addresses read zero
    always @(posedge mclk)
    begin
        if (srst)
            reg_rdata <= `SMP_R_ZERO;
        else if (reg_rd)
        begin
            case (reg_addr)
                `SMP_A_RESTART:      reg_rdata <= repeated_start_enable;
                `SMP_A_CHECK_EN:     reg_rdata <= error_check_enable;
                `SMP_A_FMT_LOW:      reg_rdata <= format_select_low;
                `SMP_A_FMT_HIGH:     reg_rdata <= format_select_high;
                `SMP_A_CONTROL:      reg_rdata <= master_control;
                `SMP_A_BLOCK_CMD:    reg_rdata <= block_cmd;
                `SMP_A_LOOP_CFG:     reg_rdata <= loop_cfg;
                `SMP_A_NOACK_ST:     reg_rdata <= noack_status;
                `SMP_A_CHECK_ST:     reg_rdata <= check_error_status;
                `SMP_A_TIMEOUT_ST:   reg_rdata <= timeout_status;
                `SMP_A_LIMIT_ST:     reg_rdata <= limit_status;
                `SMP_A_INVALID_ST:   reg_rdata <= invalid_code_status;
                `SMP_A_OVERTEMP_ST:  reg_rdata <= overtemp_status;
                `SMP_A_NOACK_MASK:   reg_rdata <= noack_mask;
                `SMP_A_CHECK_MASK:   reg_rdata <= check_error_mask;
                `SMP_A_TIMEOUT_MASK: reg_rdata <= timeout_mask;
                default:             reg_rdata <= `SMP_R_ZERO;
            endcase
        end
    end

    // ========================================================
    // Control fields to the rest of the device
    always @(posedge mclk)
    begin
        if (srst)
        begin
            poll_master_enable     <= 1'b0;
            poll_temp_hysteresis   <= `SMP_R_HYST;
            remote_a_to_modules_01 <= 1'b0;
            remote_b_to_modules_23 <= 1'b0;
            modules_from_hub       <= 1'b0;
        end
        else
        begin
            // One cycle behind the register, like every steering output
            poll_master_enable <= master_control[`SMP_B_ENABLE];
            poll_temp_hysteresis <=
                master_control[`SMP_B_HYST_HI:`SMP_B_HYST_LO];
            modules_from_hub <= master_control[`SMP_B_FROM_HUB];
            // Hub source wins over both remote overwrites
            remote_a_to_modules_01 <= master_control[`SMP_B_REMOTE_A]
                & ~master_control[`SMP_B_FROM_HUB];
            remote_b_to_modules_23 <= master_control[`SMP_B_REMOTE_B]
                & ~master_control[`SMP_B_FROM_HUB];
        end
    end

    // ========================================================
    // Loop timer and slot sequencer
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_POLL = 2'h2;
    reg [1:0]  state;
    reg [31:0] timer;
    reg [2:0]  slot;
    wire [1:0]  loop_sel = loop_cfg[`SMP_B_LOOP_HI:`SMP_B_LOOP_LO];
    // Period is (sel+1) times the base step, measured from one slot 0
    // request to the next, so the burst itself is part of the period
    wire [31:0] loop_cycles =
        LOOP_BASE_CYCLES * ({30'h0, loop_sel} + 32'h1);
    wire [15:0] fmts = {format_select_high, format_select_low};
    wire [1:0]  cur_fmt = slot_fmt(slot, fmts);
    wire        hub_slot = (slot <= `SMP_SLOT_HUB_LAST);

    // Attribute decode for the slot about to be requested. Code 11 is
    // block read on slots 0-3, literal on 5-7, and refused on slot 4,
    // which then raises neither flag.
    reg         next_block;
    reg         next_literal;
    always @*
    begin
        next_block   = 1'b0;
        next_literal = 1'b0;
        if (cur_fmt == `SMP_FMT_SPECIAL)
        begin
            if (slot < `SMP_SLOT_HUB_LAST)
                next_block = 1'b1;
            else if (!hub_slot)
                next_literal = 1'b1;
            else
                next_block = 1'b0;
        end
    end

    always @(posedge mclk)
    begin
        if (srst)
        begin
            state          <= ST_IDLE;
            timer          <= 32'h0;
            slot           <= 3'h0;
            poll_start     <= 1'b0;
            poll_slot      <= 3'h0;
            poll_restart   <= 1'b0;
            poll_check     <= 1'b0;
            poll_format    <= 2'h0;
            poll_block     <= 1'b0;
            poll_literal   <= 1'b0;
            poll_block_cmd <= `SMP_R_BLOCK_CMD;
        end
        else
        begin
            poll_start <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    slot  <= 3'h0;
                    timer <= 32'h0;
                    if (master_control[`SMP_B_ENABLE])
                        state <= ST_POLL;
                end
                ST_POLL:
                begin
                    // One request per slot, with that slot's settings
                    poll_start   <= 1'b1;
                    poll_slot    <= slot;
                    poll_restart <= repeated_start_enable[slot];
                    poll_check   <= error_check_enable[slot];
                    poll_format  <= cur_fmt;
                    poll_block   <= next_block;
                    poll_literal <= next_literal;
                    poll_block_cmd <= block_cmd;
                    // The loop timer runs through the burst as well
                    timer <= timer + 32'h1;
                    if (slot == `SMP_SLOT_LAST)
                        state <= ST_WAIT;
                    slot <= slot + 3'h1;
                end
                ST_WAIT:
                begin
                    // A period shorter than one burst stretches to nine
                    // cycles; real settings are far longer
                    if (!master_control[`SMP_B_ENABLE])
                        state <= ST_IDLE;
                    else if (timer + 32'h1 >= loop_cycles)
                    begin
                        timer <= 32'h0;
                        state <= ST_POLL;
                    end
                    else
                        timer <= timer + 32'h1;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // smp_poll_regs
`default_nettype wire

// ### smp_regs_map.vh
`ifndef SMP_REGS_MAP_VH
`define SMP_REGS_MAP_VH
`define SMP_A_RESTART      8'hB0
`define SMP_A_CHECK_EN     8'hB1
`define SMP_A_FMT_LOW      8'hB2
`define SMP_A_FMT_HIGH     8'hB3
`define SMP_A_CONTROL      8'hB5
`define SMP_A_NOACK_ST     8'hB6
`define SMP_A_CHECK_ST     8'hB7
`define SMP_A_TIMEOUT_ST   8'hB8
`define SMP_A_LIMIT_ST     8'hB9
`define SMP_A_INVALID_ST   8'hBA
`define SMP_A_OVERTEMP_ST  8'hBB
`define SMP_A_NOACK_MASK   8'hBC
`define SMP_A_CHECK_MASK   8'hBD
`define SMP_A_TIMEOUT_MASK 8'hBE
`define SMP_A_BLOCK_CMD    8'h99
`define SMP_A_LOOP_CFG     8'hC7
`define SMP_R_RESTART      8'hFF
`define SMP_R_CHECK_EN     8'h00
`define SMP_R_FMT_LOW      8'h03
`define SMP_R_FMT_HIGH     8'h00
`define SMP_R_CONTROL      8'h08
`define SMP_R_ZERO         8'h00
`define SMP_R_BLOCK_CMD    8'h40
`define SMP_R_LOOP_CFG     8'h00
`define SMP_R_HYST         4'h4
`define SMP_B_ENABLE       0
`define SMP_B_HYST_HI      4
`define SMP_B_HYST_LO      1
`define SMP_B_REMOTE_A     5
`define SMP_B_REMOTE_B     6
`define SMP_B_FROM_HUB     7
`define SMP_B_LOOP_HI      7
`define SMP_B_LOOP_LO      6
`define SMP_INVALID_MASK   8'h1F
`define SMP_FMT_SIGNED     2'h0
`define SMP_FMT_SPD        2'h1
`define SMP_FMT_UNSIGNED   2'h2
`define SMP_FMT_SPECIAL    2'h3
`define SMP_LOOP_BASE_MS   250
`define SMP_CLK_HZ         20000000
`define SMP_SLOT_LAST      3'h7
`define SMP_SLOT_HUB_LAST  3'h4
`endif

// ### smp_poll_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module smp_poll_regs_asserts (
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       poll_start,
    input wire logic [2:0] poll_slot,
    input wire logic [1:0] poll_format,
    input wire logic       poll_block,
    input wire logic       poll_literal,
    input wire logic       result_valid,
    input wire logic       remote_a_to_modules_01,
    input wire logic       remote_b_to_modules_23,
    input wire logic       modules_from_hub,
    input wire logic       poll_master_enable,
    input wire logic       error_alert
);
    // ================================
    // Port relations of the poll block
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    property p_step; poll_start && poll_slot != 3'h7 |=> poll_start
        && poll_slot == $past(poll_slot) + 3'h1; endproperty
    a_step: assert property (p_step)
        else $error("slot order broken");
    property p_gap; poll_start && poll_slot == 3'h7 |=> !poll_start; endproperty
    a_gap: assert property (p_gap)
        else $error("no wait after burst");
    property p_open; poll_start && poll_slot == 3'h0
        |-> $past(poll_master_enable); endproperty
    a_open: assert property (p_open)
        else $error("burst while disabled");
    property p_blk; poll_start && poll_slot < 3'h4
        |-> poll_block == (poll_format == 2'h3) && !poll_literal; endproperty
    a_blk: assert property (p_blk)
        else $error("block read flag wrong");
    property p_s4; poll_start && poll_slot == 3'h4
        |-> !poll_block && !poll_literal; endproperty
    a_s4: assert property (p_s4)
        else $error("slot 4 reserved code used");
    property p_lit; poll_start && poll_slot > 3'h4
        |-> poll_literal == (poll_format == 2'h3) && !poll_block; endproperty
    a_lit: assert property (p_lit)
        else $error("literal flag wrong");
    property p_hub; modules_from_hub
        |-> !remote_a_to_modules_01 && !remote_b_to_modules_23; endproperty
    a_hub: assert property (p_hub)
        else $error("hub source not overriding");
    property p_inv; reg_rd && reg_addr == 8'hBA
        |=> reg_rdata[7:5] == 3'h0; endproperty
    a_inv: assert property (p_inv)
        else $error("invalid code spare bits set");
    property p_alert; $rose(error_alert)
        |-> $past(result_valid) || $past(reg_wr); endproperty
    a_alert: assert property (p_alert)
        else $error("alert rose without cause");
endmodule // smp_poll_regs_asserts
bind smp_poll_regs smp_poll_regs_asserts u_chk (.mclk(mclk), .srst(srst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .poll_start(poll_start), .poll_slot(poll_slot),
    .poll_format(poll_format), .poll_block(poll_block),
    .poll_literal(poll_literal), .result_valid(result_valid),
    .remote_a_to_modules_01(remote_a_to_modules_01),
    .remote_b_to_modules_23(remote_b_to_modules_23),
    .modules_from_hub(modules_from_hub),
    .poll_master_enable(poll_master_enable), .error_alert(error_alert));
`default_nettype wire

// ### smp_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module smp_sensor_model (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        poll_start,
    input wire logic [2:0]  poll_slot,
    input wire logic        slow,
    input wire logic [47:0] fault_map,
    output logic            result_valid,
    output logic [2:0]      result_slot,
    output logic [5:0]      result_flags
);
    // ================================
    // Far-side sensors: delay line of requests, answered fast or slow
    logic [3:0] pipe [16];
    logic       tog;
    logic [3:0] tap;
    always @(posedge mclk)
    begin
        pipe[0] <= srst ? 4'h0 : {poll_start, poll_slot};
        for (int i = 1; i < 16; i++) pipe[i] <= srst ? 4'h0 : pipe[i-1];
        tog <= srst ? 1'b0 : ~tog;
    end
    // Outside an answer the lines churn, so stale flags cannot pass
    assign tap = slow ? pipe[12] : pipe[0];
    assign result_valid = tap[3];
    assign result_slot = tap[3] ? tap[2:0] : {3{tog}};
    assign result_flags = tap[3] ? fault_map[tap[2:0]*6 +: 6] : {6{tog}};
endmodule // smp_sensor_model
`default_nettype wire

// ### tb_smbus_master_poll_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_smbus_master_poll_regs;
    localparam int LB = 10;
    logic mclk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
    logic [47:0] fault_map = 48'h0;
    wire logic [7:0] reg_rdata, poll_block_cmd;
    wire logic [5:0] res_flags;
    wire logic [3:0] poll_temp_hysteresis;
    wire logic [2:0] poll_slot, result_slot;
    wire logic [1:0] poll_format;
    wire logic poll_start, poll_restart, poll_check, poll_block, poll_literal;
    wire logic result_valid, error_alert, poll_master_enable;
    wire logic remote_a_to_modules_01, remote_b_to_modules_23, modules_from_hub;
    int rm [256];
    int n_fail = 0, comparisons = 0, cyc = 0, p0 = -1, sel, nxt = 0, f;
    logic [7:0] al [18] = '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB5, 8'hB6, 8'hB7,
        8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'h99, 8'hC7,
        8'h42, 8'hB4};
    always #25 mclk = ~mclk;
    smp_poll_regs #(.LOOP_BASE_CYCLES(LB)) uut (.mclk(mclk), .srst(srst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .poll_start(poll_start),
        .poll_slot(poll_slot), .poll_restart(poll_restart),
        .poll_check(poll_check), .poll_format(poll_format),
        .poll_block(poll_block), .poll_literal(poll_literal),
        .poll_block_cmd(poll_block_cmd), .result_valid(result_valid),
        .result_slot(result_slot), .result_noack(res_flags[0]),
        .result_check_err(res_flags[1]), .result_timeout(res_flags[2]),
        .result_out_of_limit(res_flags[3]),
        .result_invalid_code(res_flags[4]), .result_overtemp(res_flags[5]),
        .remote_a_to_modules_01(remote_a_to_modules_01),
        .remote_b_to_modules_23(remote_b_to_modules_23),
        .modules_from_hub(modules_from_hub),
        .poll_temp_hysteresis(poll_temp_hysteresis),
        .poll_master_enable(poll_master_enable), .error_alert(error_alert));
    smp_sensor_model u_far (.mclk(mclk), .srst(srst), .slow(slow),
        .poll_start(poll_start), .poll_slot(poll_slot),
        .fault_map(fault_map), .result_valid(result_valid),
        .result_slot(result_slot), .result_flags(res_flags));
    // ================================
    // Shared checking and register tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s exp %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Model keeps only writable places; status and holes stay as reset
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk);
        {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
        @(negedge mclk);
        reg_wr = 1'b0;
        if (a inside {8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB5, 8'hBC, 8'hBD, 8'hBE,
                      8'h99, 8'hC7}) rm[a] = v;
    endtask
    task automatic rd(input logic [7:0] a, input int exp);
        @(negedge mclk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge mclk);
        reg_rd = 1'b0;
        chk(reg_rdata, exp[7:0], "reg");
    endtask
    task automatic steer(input logic [7:0] v);
        chk({modules_from_hub, remote_b_to_modules_23, remote_a_to_modules_01,
             poll_temp_hysteresis, poll_master_enable},
            {v[7], v[6] & ~v[7], v[5] & ~v[7], v[4:1], v[0]}, "ctl");
    endtask
    function automatic int st_exp(int k);
        int v = 0;
        for (int n = 0; n < 8; n++) v |= int'(fault_map[n*6+k]) << n;
        return k == 4 ? v & 8'h1F : v;
    endfunction
    function automatic logic al_exp();
        logic a = 1'b0;
        for (int n = 0; n < 8; n++) a |= fault_map[n*6] & ~rm[8'hBC][n]
            | fault_map[n*6+1] & ~rm[8'hBD][n] | fault_map[n*6+2] & ~rm[8'hBE][n];
        return a;
    endfunction
    // Watch every poll request mid-cycle, away from its launching edge
    always @(negedge mclk)
    begin
        cyc++;
        if (poll_start && !srst)
        begin
            f = (nxt < 4 ? rm[8'hB2] >> (2*nxt) : rm[8'hB3] >> (2*nxt-8)) & 3;
            chk(poll_slot, nxt, "slot");
            chk({poll_restart, poll_check}, {rm[8'hB0][nxt], rm[8'hB1][nxt]},
                "rs");
            chk({poll_format, poll_block, poll_literal}, {f[1:0], nxt < 4 &&
                f == 3, nxt > 4 && f == 3}, "fmt");
            chk(poll_block_cmd, rm[8'h99], "cmd");
            if (nxt == 0 && p0 >= 0)
                chk(cyc - p0, LB * (sel + 1), "per");
            if (nxt == 0) p0 = cyc;
            nxt = (nxt + 1) % 8;
        end
    end
    // Hang guard, far above the planned run length
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        end_sim();
    end
    initial
    begin
        void'($urandom(32'hd7e9));
        foreach (rm[i]) rm[i] = 0;
        {rm[8'hB0], rm[8'hB2], rm[8'hB5], rm[8'h99]} = {32'hFF, 32'h3, 32'h8, 32'h40};
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        srst = 1'b0;
        steer(8'h08);
        foreach (al[i]) rd(al[i], rm[al[i]]);
        foreach (al[i]) wr(al[i], 8'($urandom) & (al[i] == 8'hB5 ? 8'hFE : 8'hFF));
        foreach (al[i]) rd(al[i], rm[al[i]]);
        for (int i = 0; i < 6; i++)
        begin
            d = {7'($urandom), 1'b0};
            wr(8'hB5, d);
            repeat (2) @(negedge mclk);
            steer(d);
        end
        wr(8'hB5, 8'h08);
        for (sel = 0; sel < 4; sel++)
        begin
            repeat (60) @(negedge mclk);
            fault_map = {16'($urandom), 32'($urandom)};
            slow = sel[0];
            foreach (al[i]) if (al[i] != 8'hB5) wr(al[i], 8'($urandom));
            wr(8'hC7, {sel[1:0], 6'($urandom)});
            p0 = -1;
            nxt = 0;
            wr(8'hB5, 8'h09);
            repeat (3 * (8 + LB * (sel + 1)) + 20) @(negedge mclk);
            steer(8'h09);
            for (int k = 0; k < 6; k++) rd(8'hB6 + k, st_exp(k));
            chk(error_alert, al_exp(), "alert");
            wr(8'hB5, 8'h08);
        end
        end_sim();
    end
endmodule // tb_smbus_master_poll_regs
`default_nettype wire
